/* rtl/sgp_gpio_bank.v */
/*
 General purpose pin bank of a packet switch: seven pins, each a sampled
 input or a driven output; pins 0, 2, 4, 5 and 6 can also serve an alternate function.
 Assumes the configuration logic of the upstream port (same clock) drives
 the function, direction and data-write ports and reads the level vector;
 pins arrive asynchronously and are resolved by the pad from pin_oe_o.
*/
`timescale 1ns/100ps
`include "sgp_map.vh"

module sgp_gpio_bank #(
   parameter PIN_COUNT = `SGP_PIN_COUNT,
   parameter SAMPLE_CYC = `SGP_SAMPLE_CYC
) (
   input wire mclk_i, // Core clock, 100 MHz
   input wire rst_i, // Asynchronous reset, active high
   input wire [PIN_COUNT-1:0] pin_function_select_i, // 1: alternate function
   input wire [PIN_COUNT-1:0] pin_direction_select_i, // 1: output, 0: input
   input wire pin_level_wr_i, // Write strobe for the data vector
   input wire [PIN_COUNT-1:0] pin_level_wdata_i, // Data vector write value
   output reg [PIN_COUNT-1:0] pin_level_value_o, // Sampled pin levels
   output reg [PIN_COUNT-1:0] pin_drive_value_o, // Retained written data
   input wire port2_reset_out_n_i, // Core reset for downstream port 2
   input wire port1_reset_out_n_i, // Core reset for downstream port 1
   input wire port3_reset_out_n_i, // Core reset for downstream port 3
   input wire general_event_out_n_i, // Core general purpose event
   output reg expander0_irq_in_n_o, // Expander 0 interrupt to core
   input wire [PIN_COUNT-1:0] pin_in_i, // Pin levels from the pads
   output reg [PIN_COUNT-1:0] pin_out_o, // Pin drive values
   output reg [PIN_COUNT-1:0] pin_oe_o // Pin output enables, high drives
);

   // One-hot pin modes
   localparam MODE_IN = 3'b001;
   localparam MODE_OUT = 3'b010;
   localparam MODE_ALT = 3'b100;
   // Pins whose alternate function drives the pin
   localparam [PIN_COUNT-1:0] ALT_OE = `SGP_ALT_OE_MASK;
   localparam [PIN_COUNT-1:0] RST_DRIVE = `SGP_DRIVE_RST;
   // Four count bits limit SAMPLE_CYC to 16 at most
   localparam [`SGP_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CYC[`SGP_CNT_W-1:0] - 4'h1;

   reg [PIN_COUNT-1:0] pin_meta;
   reg [PIN_COUNT-1:0] pin_sync;
   reg [`SGP_CNT_W-1:0] sample_cnt;
   reg [`SGP_CNT_W-1:0] next_sample_cnt;
   reg [PIN_COUNT-1:0] alt_value;
   reg next_irq;
   wire sample_tick;
   wire irq_pin_alt;
   genvar i;

   // Mode decode, shared by the pin drivers and the interrupt input
   function [2:0] pin_mode;
      input func_bit;
      input dir_bit;
      if (func_bit) begin
         pin_mode = MODE_ALT;
      end else if (dir_bit) begin
         pin_mode = MODE_OUT;
      end else begin
         pin_mode = MODE_IN;
      end
   endfunction

   // Two flops per pin; nothing but pin_sync reads pin_meta
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_sync
         always @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               pin_meta[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
            end else begin
               pin_meta[i] <= pin_in_i[i];
               pin_sync[i] <= pin_meta[i];
            end
         end
      end
   endgenerate

   // Samples are spaced so a glitchy board signal is not seen faster than 128 ns
   assign sample_tick = (sample_cnt == SAMPLE_LAST);

   always @* begin
      if (sample_tick) begin
         next_sample_cnt = {`SGP_CNT_W{1'b0}};
      end else begin
         next_sample_cnt = sample_cnt + 4'h1;
      end
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sample_cnt <= {`SGP_CNT_W{1'b0}};
      end else begin
         sample_cnt <= next_sample_cnt;
      end
   end

   // Every pin is sampled, whatever its mode, so a read shows the real level
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_level
         always @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               pin_level_value_o[i] <= 1'b0;
            end else if (sample_tick) begin
               pin_level_value_o[i] <= pin_sync[i];
            end
         end
      end
   endgenerate

   // Written data is kept even while the pin is not an output, so a pin
   // switched to output starts from a value software chose beforehand
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_drive
         always @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               pin_drive_value_o[i] <= RST_DRIVE[i];
            end else if (pin_level_wr_i) begin
               pin_drive_value_o[i] <= pin_level_wdata_i[i];
            end
         end
      end
   endgenerate

   // Alternate drive values; pins without an output function idle high
   always @* begin
      alt_value = {PIN_COUNT{1'b1}};
      alt_value[`SGP_BIT_PORT2_RST] = port2_reset_out_n_i;
      alt_value[`SGP_BIT_PORT1_RST] = port1_reset_out_n_i;
      alt_value[`SGP_BIT_PORT3_RST] = port3_reset_out_n_i;
      alt_value[`SGP_BIT_EVENT] = general_event_out_n_i;
   end

   // Pin drivers; the pad's enable and value are both registered so the
   // board never sees a decode glitch when the mode bits change
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pin
         reg next_out;
         reg next_oe;
         wire [2:0] mode;

         assign mode = pin_mode(pin_function_select_i[i], pin_direction_select_i[i]);

         always @* begin
            next_out = pin_drive_value_o[i];
            next_oe = 1'b0;
            case (mode)
               MODE_IN: begin
                  next_out = pin_drive_value_o[i];
                  next_oe = 1'b0;
               end
               MODE_OUT: begin
                  // Core reset and event signals never reach a plain pin
                  next_out = pin_drive_value_o[i];
                  next_oe = 1'b1;
               end
               MODE_ALT: begin
                  // Direction is ignored while the alternate function owns the pin
                  next_out = alt_value[i];
                  next_oe = ALT_OE[i];
               end
               default: begin
                  next_out = 1'b0;
                  next_oe = 1'b0;
               end
            endcase
         end

         always @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               pin_out_o[i] <= 1'b0;
               pin_oe_o[i] <= 1'b0;
            end else begin
               pin_out_o[i] <= next_out;
               pin_oe_o[i] <= next_oe;
            end
         end
      end
   endgenerate

   // Interrupt input reads inactive unless its pin is in alternate mode
   assign irq_pin_alt = (pin_mode(pin_function_select_i[`SGP_BIT_EXP0_IRQ],
      pin_direction_select_i[`SGP_BIT_EXP0_IRQ]) == MODE_ALT);

   always @* begin
      if (irq_pin_alt) begin
         next_irq = pin_sync[`SGP_BIT_EXP0_IRQ];
      end else begin
         next_irq = 1'b1;
      end
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         expander0_irq_in_n_o <= 1'b1;
      end else begin
         expander0_irq_in_n_o <= next_irq;
      end
   end

endmodule // sgp_gpio_bank

/* rtl/sgp_map.vh */
/*
 Constants for the switch general purpose pin bank: pin count, reset
 values, bit positions of the alternate functions and sample timing.
 Assumes it is included by bare name from the bank's design file.
*/
`ifndef SGP_MAP_VH
`define SGP_MAP_VH

`define SGP_PIN_COUNT 7
// Reset values of the three per-pin vectors
`define SGP_FUNC_RST 7'h00
`define SGP_DIR_RST 7'h00
`define SGP_DRIVE_RST 7'h00
// Bit positions in the vectors of the pins that carry alternate functions
`define SGP_BIT_PORT2_RST 0
`define SGP_BIT_EXP0_IRQ 2
`define SGP_BIT_EVENT 4
`define SGP_BIT_PORT1_RST 5
`define SGP_BIT_PORT3_RST 6
// Pins whose alternate function drives the pin
`define SGP_ALT_OE_MASK 7'h71
// Input sample spacing: least time, rounded up to whole cycles
`define SGP_SAMPLE_NS 128
`define SGP_CLK_NS 10
`define SGP_SAMPLE_CYC ((`SGP_SAMPLE_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_CNT_W 4

`endif

/* testbench/sgp_board_model.sv */
/* Board pads; assumes the bench sets board levels. */
`timescale 1ns/100ps
module sgp_board_model (
   input wire [6:0] out_i, oe_i, ext_i, // Drive, enable, board
   output wire [6:0] pin_o // Pads
);
   assign pin_o = oe_i & out_i | ~oe_i & ext_i; // Untimed
endmodule // sgp_board_model

/* testbench/sgp_gpio_bank_chk.sv */
/* Pin bank checker; assumes one clock. */
`timescale 1ns/100ps
module sgp_gpio_bank_chk (
   input wire mclk_i, rst_i, pin_level_wr_i, port2_reset_out_n_i, // Ctl
   input wire [6:0] pin_function_select_i, pin_direction_select_i, pin_level_wdata_i, // Cfg
   input wire general_event_out_n_i, expander0_irq_in_n_o, // Event, irq
   input wire [6:0] pin_drive_value_o, pin_out_o, pin_oe_o // Pins
);
   wire [6:0] fn = pin_function_select_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_wr; pin_level_wr_i |=> pin_drive_value_o == $past(pin_level_wdata_i); endproperty
   a_wr: assert property (p_wr) else $error("write");
   property p_oe; fn == 7'h00 |=> pin_oe_o == $past(pin_direction_select_i); endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_alt; fn == 7'h7F |=> pin_oe_o == 7'h71; endproperty
   a_alt: assert property (p_alt) else $error("alt");
   property p_p2; fn[0] |=> pin_out_o[0] == $past(port2_reset_out_n_i); endproperty
   a_p2: assert property (p_p2) else $error("port2");
   property p_ev; fn[4] |=> pin_out_o[4] == $past(general_event_out_n_i); endproperty
   a_ev: assert property (p_ev) else $error("event");
   property p_irq; !fn[2] |=> expander0_irq_in_n_o; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_gp; fn == 7'h00 |=> pin_out_o == $past(pin_drive_value_o); endproperty
   a_gp: assert property (p_gp) else $error("gpio out");
endmodule // sgp_gpio_bank_chk
bind sgp_gpio_bank sgp_gpio_bank_chk chk (.*);

/* testbench/tb_sgp_gpio_bank.sv */
/* Pin bank bench; assumes board model, checker. */
`timescale 1ns/100ps
module tb_sgp_gpio_bank;
   logic mclk_i = 0, rst_i = 1, pin_level_wr_i = 0, port2_reset_out_n_i = 1;
   logic port1_reset_out_n_i = 1, port3_reset_out_n_i = 1, general_event_out_n_i = 1;
   logic [6:0] pin_function_select_i = 0, pin_direction_select_i = 0, pin_level_wdata_i = 0;
   logic [6:0] ext = 0, pin_level_value_o, pin_drive_value_o, pin_in_i, pin_out_o, pin_oe_o;
   logic expander0_irq_in_n_o;
   int miscompares = 0, total_checks = 0;
   always #5 mclk_i = ~mclk_i;
   sgp_gpio_bank dut (.*);
   sgp_board_model brd (.out_i(pin_out_o), .oe_i(pin_oe_o), .ext_i(ext), .pin_o(pin_in_i));
   task step(int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task chk(string s, logic [6:0] v, e);
      total_checks++;
      if (v !== e) $display("unexpected %s: expected %h seen %h", s, e, v);
      if (v !== e) miscompares++;
   endtask
   task report_and_stop;
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task t_reset;
      chk("oe", pin_oe_o, 7'h00);
      chk("drv", pin_drive_value_o, 7'h00);
      chk("irq", {6'h00, expander0_irq_in_n_o}, 7'h01);
   endtask
   task t_retain;
      pin_level_wdata_i = 7'h55;
      pin_level_wr_i = 1;
      step(1);
      pin_level_wr_i = 0;
      step(1);
      chk("drv", pin_drive_value_o, 7'h55);
      chk("oe", pin_oe_o, 7'h00);
      step(15);
      chk("lvl", pin_level_value_o, 7'h00);
   endtask
   task t_input;
      pin_direction_select_i = 7'h00;
      ext = 7'h11;
      step(2);
      chk("lvl", pin_level_value_o, 7'h0A);
      step(16);
      chk("lvl", pin_level_value_o, 7'h11);
   endtask
   task t_output;
      pin_level_wdata_i = 7'h0A;
      pin_level_wr_i = 1;
      step(1);
      pin_level_wr_i = 0;
      pin_direction_select_i = 7'h0A;
      step(18);
      chk("out", pin_out_o, 7'h0A);
      chk("oe", pin_oe_o, 7'h0A);
      chk("lvl", pin_level_value_o, 7'h0A);
   endtask
   task t_alt;
      port2_reset_out_n_i = 0;
      pin_function_select_i = 7'h7F;
      ext = 7'h00;
      step(4);
      chk("alt", pin_out_o, 7'h7E);
      chk("aoe", pin_oe_o, 7'h71);
      chk("irq", {6'h00, expander0_irq_in_n_o}, 7'h00);
      general_event_out_n_i = 0;
      step(1);
      chk("evt", pin_out_o, 7'h6E);
      pin_function_select_i = 7'h00;
      step(2);
      chk("irq", {6'h00, expander0_irq_in_n_o}, 7'h01);
      chk("gp", pin_out_o, 7'h0A);
   endtask
   initial begin
      step(20);
      t_reset;
      rst_i = 0;
      t_retain;
      t_output;
      t_input;
      t_alt;
      report_and_stop;
   end
endmodule // tb_sgp_gpio_bank
